// ===== sbg_cfg.svh
// Constants of the serial baud rate generator: offsets, fields, resets.
`ifndef SBG_CFG_SVH
`define SBG_CFG_SVH

// Register offsets on the register port.
`define SBG_OFS_DIV_LOW 3'h0
`define SBG_OFS_DIV_HIGH 3'h1
`define SBG_OFS_CTRL 3'h2
`define SBG_OFS_CNT_LOW 3'h3
`define SBG_OFS_CNT_HIGH 3'h4
`define SBG_OFS_PRE 3'h5

// Bit positions and width of the baud control register.
`define SBG_CTRL_SYNC 0
`define SBG_CTRL_WIDE 1
`define SBG_CTRL_HS 2
`define SBG_CTRL_W 3

// Reset values.
`define SBG_RST_DIV 8'h00
`define SBG_RST_CTRL 3'h0

// Last prescaler count for each prescale factor of 64, 16 and 4.
`define SBG_PRE64_LAST 6'h3f
`define SBG_PRE16_LAST 6'h0f
`define SBG_PRE4_LAST 6'h03

`endif

// ===== sbg_pkg.sv
// Types shared by the serial baud rate generator modules.
`default_nettype none
package sbg_pkg;
	typedef enum logic [1:0] {SBG_DIV64, SBG_DIV16, SBG_DIV4} sbg_presc_t;

	typedef struct packed {
		logic [5:0] pcnt;
		logic bit_tick;
	} sbg_pre_t;

	typedef struct packed {
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [2:0] ctrl;
		logic [15:0] cnt;
		logic rate_tick;
		logic [7:0] rdata;
	} sbg_main_t;
endpackage
`default_nettype wire

// ===== sbg_prescaler.sv
// Prescaler that turns divisor rate ticks into bit clock ticks.
`include "sbg_cfg.svh"
`default_nettype none
module sbg_prescaler
	import sbg_pkg::*;
(
	// Clock and synchronised reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control from the divisor counter and the prescale select decode.
	input wire logic restart,
	input wire logic rate_tick,
	input wire sbg_presc_t presc_sel,
	// Results.
	output logic [5:0] pcnt,
	output logic bit_tick
);
	sbg_pre_t q;
	sbg_pre_t d;
	logic [5:0] last;

	always_comb
	begin
		d = q;
		d.bit_tick = 1'b0;
		case (presc_sel)
			SBG_DIV64: last = `SBG_PRE64_LAST;
			SBG_DIV16: last = `SBG_PRE16_LAST;
			SBG_DIV4: last = `SBG_PRE4_LAST;
			default: last = `SBG_PRE64_LAST;
		endcase
		if (restart)
			d.pcnt = 6'h00;
		else if (rate_tick)
		begin
			// A narrowed factor after a mode change must still wrap.
			if (q.pcnt >= last)
			begin
				d.pcnt = 6'h00;
				d.bit_tick = 1'b1;
			end
			else
				d.pcnt = q.pcnt + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign pcnt = q.pcnt;
	assign bit_tick = q.bit_tick;

	sequence s_wrap;
		rate_tick && !restart && q.pcnt == last;
	endsequence

	property p_wrap;
		@(posedge clk) disable iff (!rst_n)
		s_wrap |=> q.bit_tick && q.pcnt == 6'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("Prescaler did not wrap with a bit tick.");

	property p_bit_cause;
		@(posedge clk) disable iff (!rst_n)
		q.bit_tick |-> $past(rate_tick) && !$past(restart);
	endproperty
	a_bit_cause: assert property (p_bit_cause)
		else $error("Bit tick without a rate tick.");
endmodule
`default_nettype wire

// ===== sbg_top.sv
// Serial baud rate generator: divisor registers, counter and prescale.
//
// What this block does
// - Low register holds divisor bits 7-0.
// - High register holds divisor bits 15-8.
// - Writing low register restarts the counter.
// - Writing high register restarts the counter.
// - Narrow width leaves high register out of the divisor; writing it still restarts the counter.
// - Async narrow slow: rate is clock/64(n+1).
// - Async wide slow or narrow fast: /16(n+1).
// - Sync, or async wide fast: /4(n+1).
// - Divisor is high byte then low byte.
//
// The implementer's own choices: the register offsets and the strobed register port.
`include "sbg_cfg.svh"
`default_nettype none
module sbg_top
	import sbg_pkg::*;
(
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic RST_B,
	// Register port.
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Generated ticks.
	output logic RATE_TICK,
	output logic BAUD_TICK
);

	////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_s1_q;
	logic rst_n;

	// Assertion is immediate; release waits two edges to avoid metastability.
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State and next state.

	sbg_main_t q;
	sbg_main_t d;
	logic restart;
	logic [15:0] n_eff;
	logic [15:0] n_next;
	sbg_presc_t presc_sel;
	logic [5:0] pcnt;
	logic sync_m;
	logic wide_m;
	logic hs_m;

	assign sync_m = q.ctrl[`SBG_CTRL_SYNC];
	assign wide_m = q.ctrl[`SBG_CTRL_WIDE];
	assign hs_m = q.ctrl[`SBG_CTRL_HS];

	always_comb
	begin
		d = q;
		d.rate_tick = 1'b0;
		d.rdata = 8'h00;
		restart = 1'b0;
		// Narrow width uses low byte only.
		if (wide_m)
			n_eff = {q.div_high, q.div_low};
		else
			n_eff = {8'h00, q.div_low};
		if (WR)
		begin
			case (ADDR)
				`SBG_OFS_DIV_LOW:
				begin
					d.div_low = WDATA;
					restart = 1'b1;
				end
				`SBG_OFS_DIV_HIGH:
				begin
					d.div_high = WDATA;
					restart = 1'b1;
				end
				`SBG_OFS_CTRL:
					d.ctrl = WDATA[`SBG_CTRL_W-1:0];
				default:
					d.ctrl = q.ctrl;
			endcase
		end
		if (d.ctrl[`SBG_CTRL_WIDE])
			n_next = {d.div_high, d.div_low};
		else
			n_next = {8'h00, d.div_low};
		if (restart)
			d.cnt = n_next;
		else if (q.cnt == 16'h0000)
		begin
			d.cnt = n_eff;
			d.rate_tick = 1'b1;
		end
		else
			d.cnt = q.cnt - 16'h0001;
		if (RD)
		begin
			case (ADDR)
				`SBG_OFS_DIV_LOW: d.rdata = q.div_low;
				`SBG_OFS_DIV_HIGH: d.rdata = q.div_high;
				`SBG_OFS_CTRL: d.rdata = {5'h00, q.ctrl};
				`SBG_OFS_CNT_LOW: d.rdata = q.cnt[7:0];
				`SBG_OFS_CNT_HIGH: d.rdata = q.cnt[15:8];
				`SBG_OFS_PRE: d.rdata = {2'h0, pcnt};
				default: d.rdata = 8'h00;
			endcase
		end
	end

	// A mode change alone does not restart; the new factor applies at once.
	always_comb
	begin
		if (sync_m || (wide_m && hs_m))
			presc_sel = SBG_DIV4;
		// Async wide slow or narrow fast.
		else if (wide_m || hs_m)
			presc_sel = SBG_DIV16;
		else
			presc_sel = SBG_DIV64;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q.div_low <= `SBG_RST_DIV;
			q.div_high <= `SBG_RST_DIV;
			q.ctrl <= `SBG_RST_CTRL;
			q.cnt <= 16'h0000;
			q.rate_tick <= 1'b0;
			q.rdata <= 8'h00;
		end
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler.

	sbg_prescaler u_pre (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.restart(restart),
		.rate_tick(q.rate_tick),
		.presc_sel(presc_sel),
		.pcnt(pcnt),
		.bit_tick(BAUD_TICK)
	);

	assign RDATA = q.rdata;
	assign RATE_TICK = q.rate_tick;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_wr_low;
		WR && ADDR == `SBG_OFS_DIV_LOW;
	endsequence

	sequence s_wr_high;
		WR && ADDR == `SBG_OFS_DIV_HIGH;
	endsequence

	sequence s_rd_low;
		RD && ADDR == `SBG_OFS_DIV_LOW;
	endsequence

	sequence s_rd_high;
		RD && ADDR == `SBG_OFS_DIV_HIGH;
	endsequence

	sequence s_tick_one;
		q.rate_tick && q.cnt == 16'h0001 && !restart;
	endsequence

	property p_low_store;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_wr_low |=> q.div_low == $past(WDATA);
	endproperty
	a_low_store: assert property (p_low_store)
		else $error("Low divisor byte not stored.");

	property p_high_store;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_wr_high |=> q.div_high == $past(WDATA);
	endproperty
	a_high_store: assert property (p_high_store)
		else $error("High divisor byte not stored.");

	property p_low_restart;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_wr_low |=> q.cnt == n_eff && !q.rate_tick;
	endproperty
	a_low_restart: assert property (p_low_restart)
		else $error("Low write did not restart the counter.");

	property p_high_restart;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_wr_high |=> q.cnt == n_eff && pcnt == 6'h00;
	endproperty
	a_high_restart: assert property (p_high_restart)
		else $error("High write did not restart the counter.");

	property p_narrow;
		@(posedge SYS_CLK) disable iff (!rst_n)
		q.rate_tick && !$past(wide_m) |->
			q.cnt == {8'h00, $past(q.div_low)};
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("High byte used in narrow mode.");

	property p_pair;
		@(posedge SYS_CLK) disable iff (!rst_n)
		q.rate_tick && $past(wide_m) |->
			q.cnt == {$past(q.div_high), $past(q.div_low)};
	endproperty
	a_pair: assert property (p_pair)
		else $error("Divisor bytes paired wrongly.");

	property p_rate64;
		@(posedge SYS_CLK) disable iff (!rst_n)
		(!sync_m && !wide_m && !hs_m) |-> presc_sel == SBG_DIV64;
	endproperty
	a_rate64: assert property (p_rate64)
		else $error("Prescale 64 not chosen.");

	property p_rate16;
		@(posedge SYS_CLK) disable iff (!rst_n)
		(!sync_m && (wide_m != hs_m)) |-> presc_sel == SBG_DIV16;
	endproperty
	a_rate16: assert property (p_rate16)
		else $error("Prescale 16 not chosen.");

	property p_rate4;
		@(posedge SYS_CLK) disable iff (!rst_n)
		(sync_m || (wide_m && hs_m)) |-> presc_sel == SBG_DIV4;
	endproperty
	a_rate4: assert property (p_rate4)
		else $error("Prescale 4 not chosen.");

	property p_reload;
		@(posedge SYS_CLK) disable iff (!rst_n)
		q.rate_tick |-> q.cnt == $past(n_eff) && $past(q.cnt) == 16'h0000;
	endproperty
	a_reload: assert property (p_reload)
		else $error("Counter did not reload from the divisor.");

	property p_spacing;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_tick_one |=>
			!q.rate_tick ##1 (q.rate_tick || $past(restart));
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("Rate tick period is not n plus one.");

	property p_low_read;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_rd_low |=> RDATA == $past(q.div_low);
	endproperty
	a_low_read: assert property (p_low_read)
		else $error("Low divisor byte read back wrongly.");

	property p_high_read;
		@(posedge SYS_CLK) disable iff (!rst_n)
		s_rd_high |=> RDATA == $past(q.div_high);
	endproperty
	a_high_read: assert property (p_high_read)
		else $error("High divisor byte read back wrongly.");

	property p_cnt_step;
		@(posedge SYS_CLK) disable iff (!rst_n)
		!restart && q.cnt != 16'h0000 |=>
			q.cnt == $past(q.cnt) - 16'h0001;
	endproperty
	a_cnt_step: assert property (p_cnt_step)
		else $error("Counter did not step down by one.");

	// A restart swallows a tick that was due, so no period runs short.
	property p_tick_cut;
		@(posedge SYS_CLK) disable iff (!rst_n)
		restart |=> !q.rate_tick && !BAUD_TICK;
	endproperty
	a_tick_cut: assert property (p_tick_cut)
		else $error("Tick seen right after a restart.");
endmodule
`default_nettype wire

// ===== sbg_dummy_end.sv
// Intentionally empty unit closing the set.
`default_nettype none
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench of the serial baud rate generator.
`include "sbg_cfg.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////
	// Clock, reset and the design.
	logic SYS_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic [2:0] ADDR = 3'h0;
	logic [7:0] WDATA = 8'h00;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [7:0] RDATA;
	logic RATE_TICK;
	logic BAUD_TICK;
	int n_errors = 0;
	int num_checks = 0;

	always #25 SYS_CLK = ~SYS_CLK;

	sbg_top u_sbg_top (
		.SYS_CLK(SYS_CLK),
		.RST_B(RST_B),
		.ADDR(ADDR),
		.WDATA(WDATA),
		.WR(WR),
		.RD(RD),
		.RDATA(RDATA),
		.RATE_TICK(RATE_TICK),
		.BAUD_TICK(BAUD_TICK)
	);

	////////////////////////////////////////////////////////////////////////
	// Shared tasks.
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, then drop to 0.
	task automatic rd(input logic [2:0] a, input logic [7:0] exp,
		input string what);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1;
		check(what, {8'h00, exp}, {8'h00, RDATA});
		@(posedge SYS_CLK);
		#1;
		check("rdata idle", 16'h0000, {8'h00, RDATA});
	endtask

	// Counts cycles from the restarting write to the first two rate ticks
	// and the first bit tick; the bound keeps a dead counter from hanging.
	task automatic meas(input int n, input int f);
		int k;
		int r1;
		int r2;
		int b;
		r1 = 0;
		r2 = 0;
		b = 0;
		for (k = 1; k <= 5000 && b == 0; k++)
		begin
			@(posedge SYS_CLK);
			#1;
			if (RATE_TICK === 1'b1 && r1 != 0 && r2 == 0)
				r2 = k;
			if (RATE_TICK === 1'b1 && r1 == 0)
				r1 = k;
			if (BAUD_TICK === 1'b1)
				b = k;
		end
		if (b == 0)
		begin
			n_errors++;
			$display("FAIL bit tick expected by cycle 5000 seen none");
			final_report();
		end
		check("first rate tick", 16'(n + 1), 16'(r1));
		check("second rate tick", 16'(2 * n + 2), 16'(r2));
		check("first bit tick", 16'(f * (n + 1) + 1), 16'(b));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		logic [2:0] c;
		int n;
		int f;
		repeat (10) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		rd(`SBG_OFS_DIV_LOW, 8'h00, "low reset");
		rd(`SBG_OFS_DIV_HIGH, 8'h00, "high reset");
		rd(`SBG_OFS_CTRL, 8'h00, "ctrl reset");
		rd(3'h6, 8'h00, "unmapped");
		wr(`SBG_OFS_DIV_LOW, 8'ha5);
		wr(`SBG_OFS_DIV_HIGH, 8'h3c);
		rd(`SBG_OFS_DIV_LOW, 8'ha5, "low readback");
		rd(`SBG_OFS_DIV_HIGH, 8'h3c, "high readback");
		// Every mode; the byte written last alternates so that each
		// register's restart is seen cutting short a running count.
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			wr(`SBG_OFS_CTRL, {5'h00, c});
			rd(`SBG_OFS_CTRL, {5'h00, c}, "ctrl readback");
			n = c[`SBG_CTRL_WIDE] ? 258 : 2;
			if (c[`SBG_CTRL_SYNC])
				f = 4;
			else if (c[`SBG_CTRL_WIDE] && c[`SBG_CTRL_HS])
				f = 4;
			else if (c[`SBG_CTRL_WIDE] ^ c[`SBG_CTRL_HS])
				f = 16;
			else
				f = 64;
			if (c[0])
			begin
				wr(`SBG_OFS_DIV_HIGH, 8'h01);
				wr(`SBG_OFS_DIV_LOW, 8'h02);
			end
			else
			begin
				wr(`SBG_OFS_DIV_LOW, 8'h02);
				wr(`SBG_OFS_DIV_HIGH, 8'h01);
			end
			meas(n, f);
		end
		// Narrow width with the high byte still 1: the divisor must be 1.
		wr(`SBG_OFS_CTRL, 8'h00);
		wr(`SBG_OFS_DIV_LOW, 8'h01);
		meas(1, 64);
		rd(`SBG_OFS_CNT_LOW, 8'h01, "count low");
		rd(`SBG_OFS_PRE, 8'h02, "prescale count");
		rd(`SBG_OFS_CNT_HIGH, 8'h00, "count high");
		final_report();
	end
endmodule
`default_nettype wire
